// file: inc/srp_consts.svh
// Register offsets, field positions and reset values of the serial port block.
// What this block does
// [R1] Power-on loads defaults, then requests output alignment.
// [R2] Reset pin low restores all register defaults.
// [R3] Both mirrored soft-reset bits set starts reset.
// [R4] Soft reset acts directly, no update needed.
// [R5] Sleep pin low powers down; registers kept.
// [R6] Serial port keeps working during sleep.
// [R7] Sleep stops PLL, VCO, input, dividers; outputs safe.
// [R8] PLL mode field; asynchronous mode stops immediately.
// [R9] Synchronous mode stops at next charge pump event.
// [R10] Distribution power-down bit removes distribution bias.
// [R11] Output modes: 00 on, 10 safe, 11 off.
// [R12] Write bits on rising, read bits on falling.
// [R13] Output-enable bit moves read data to output pin.
// [R14] Chip select high keeps data pins undriven.
// [R15] Host lowers chip select to start cycles.
// [R16] Short transfers may stall at byte boundaries.
// [R17] Abort by finishing bytes or short clocking.
// [R18] Chip select rising mid-byte ends, discards data.
// [R19] Streaming steps address per byte, ends after update register 0x232.
// [R20] Each cycle starts with sixteen-bit instruction.
// [R21] Long instruction only; bidirectional after reset.
// [R22] Instruction: direction, length, thirteen address bits.
// [R23] Length codes: one, two, three bytes, streaming.
// [R24] Writes go to shadow; update copies all.
// [R25] MSB first decrements address; LSB first increments.
// [R26] Serial writes and updates cross safely into core.
// [R27] Reset and sleep pins synchronised before use.
`ifndef SRP_CONSTS_SVH
`define SRP_CONSTS_SVH

`define SRP_NREG 563
`define SRP_ADDR_CFG 10'h000
`define SRP_ADDR_RBSEL 10'h004
`define SRP_ADDR_PLL 10'h010
`define SRP_ADDR_OUT0 10'h0F0
`define SRP_ADDR_DIST 10'h230
`define SRP_ADDR_UPD 10'h232
`define SRP_CFG_SDO 7
`define SRP_CFG_LSB 6
`define SRP_CFG_SRST_HI 5
`define SRP_CFG_SRST_LO 2
`define SRP_RBSEL_BIT 0
`define SRP_DIST_PD_BIT 1
`define SRP_SSYNC_BIT 0
`define SRP_UPD_BIT 0
`define SRP_CFG_DEF 8'h18
`define SRP_REG_DEF 8'h00
`define SRP_PLL_ASYNC 2'h1
`define SRP_PLL_SYNC 2'h3
`define SRP_OUT_SAFE 2'h2
`define SRP_LEN_STREAM 2'h3
`define SRP_INSTR_LAST 4'hF
`define SRP_INSTR_HALF 4'h8
`define SRP_BYTE_LAST 4'h7

`endif

// file: inc/srp_pkg.sv
// Types shared by the serial port block.
package srp_pkg;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_INSTR = 5'h02,
      ST_DATA = 5'h04,
      ST_STALL = 5'h08,
      ST_END = 5'h10
   } srp_state_t;
   typedef logic [9:0] srp_raddr_t;
endpackage

// file: core/srp_regfile.sv
// Shadow and active register arrays with update and soft reset.
`timescale 1ns/1ps
`include "srp_consts.svh"
module srp_regfile (
   input wire logic core_clk_i,
   input wire logic hard_rst_i,
   input wire logic we_i,
   input wire srp_pkg::srp_raddr_t waddr_i,
   input wire logic [7:0] wdata_i,
   input wire srp_pkg::srp_raddr_t raddr_i,
   output logic [7:0] rdata_o,
   output logic update_o,
   output logic [7:0] cfg_o,
   output logic [1:0] pll_mode_o,
   output logic [11:0] out_mode_o,
   output logic dist_pd_o,
   output logic soft_sync_o,
   output logic soft_rst_o
);
   logic [7:0] shd_q [0:`SRP_NREG-1];
   logic [7:0] act_q [0:`SRP_NREG-1];
   logic upd_q;
   wire upd_wr = we_i && (waddr_i == `SRP_ADDR_UPD) && wdata_i[`SRP_UPD_BIT];
   wire rb_act = act_q[`SRP_ADDR_RBSEL][`SRP_RBSEL_BIT];
   wire soft_rst = act_q[0][`SRP_CFG_SRST_HI] & act_q[0][`SRP_CFG_SRST_LO];

   function automatic logic [7:0] reg_default(input int idx);
      reg_default = (idx == 0) ? `SRP_CFG_DEF : `SRP_REG_DEF;
   endfunction

   always_ff @(posedge core_clk_i) begin
      upd_q <= !hard_rst_i && upd_wr; // see [R24]
      for (int i = 0; i < `SRP_NREG; i++) begin
         if (hard_rst_i) begin
            shd_q[i] <= reg_default(i); // see [R1] see [R2] see [R21]
            act_q[i] <= reg_default(i);
         end else if (soft_rst && i != 0) begin
            shd_q[i] <= reg_default(i); // see [R3] see [R4]
            act_q[i] <= reg_default(i);
         end else begin
            if (we_i && waddr_i == 10'(i)) begin
               shd_q[i] <= (i == `SRP_ADDR_UPD) ? (wdata_i & 8'hFE) : wdata_i;
            end
            if (i == 0 && we_i && waddr_i == `SRP_ADDR_CFG) begin
               act_q[i] <= wdata_i;
            end else if (upd_q) begin
               act_q[i] <= shd_q[i]; // see [R24]
            end
         end
      end
   end

   assign rdata_o = (raddr_i >= 10'(`SRP_NREG)) ? 8'h00 : rb_act ? act_q[raddr_i] : shd_q[raddr_i];
   assign update_o = upd_q;
   assign cfg_o = act_q[0];
   assign pll_mode_o = act_q[`SRP_ADDR_PLL][1:0];
   assign dist_pd_o = act_q[`SRP_ADDR_DIST][`SRP_DIST_PD_BIT];
   assign soft_sync_o = act_q[`SRP_ADDR_DIST][`SRP_SSYNC_BIT];
   assign soft_rst_o = soft_rst;
   for (genvar g = 0; g < 6; g++) begin : g_out
      assign out_mode_o[2*g+1:2*g] = act_q[`SRP_ADDR_OUT0 + g][1:0];
   end
endmodule // srp_regfile

// file: core/srp_pwr.sv
// Power-down control for PLL, VCO, input buffer, dividers and outputs.
`timescale 1ns/1ps
`include "srp_consts.svh"
module srp_pwr (
   input wire logic core_clk_i,
   input wire logic hard_rst_i,
   input wire logic asleep_i,
   input wire logic [1:0] pll_mode_i,
   input wire logic dist_pd_i,
   input wire logic [11:0] out_mode_i,
   input wire logic cp_event_i,
   output logic pll_pd_o,
   output logic vco_pd_o,
   output logic clkin_pd_o,
   output logic div_pd_o,
   output logic dist_pd_o,
   output logic [11:0] out_mode_o
);
   logic [11:0] mode_d;
   wire pll_async = pll_mode_i == `SRP_PLL_ASYNC;
   wire pll_sync = pll_mode_i == `SRP_PLL_SYNC;
   // Synchronous mode waits for a charge pump event so the loop never jumps.
   wire pll_pd_d = asleep_i | pll_async | (pll_sync & (pll_pd_o | cp_event_i)); // see [R8] see [R9]

   for (genvar g = 0; g < 6; g++) begin : g_mode
      assign mode_d[2*g+1:2*g] = asleep_i ? `SRP_OUT_SAFE : out_mode_i[2*g+1:2*g]; // see [R7] see [R11]
   end

   always_ff @(posedge core_clk_i) begin
      if (hard_rst_i) begin
         pll_pd_o <= 1'b0;
         vco_pd_o <= 1'b0;
         clkin_pd_o <= 1'b0;
         div_pd_o <= 1'b0;
         dist_pd_o <= 1'b0;
         out_mode_o <= 12'h000;
      end else begin
         pll_pd_o <= pll_pd_d;
         vco_pd_o <= asleep_i; // see [R5] see [R7]
         clkin_pd_o <= asleep_i;
         div_pd_o <= asleep_i;
         dist_pd_o <= dist_pd_i; // see [R10]
         out_mode_o <= mode_d;
      end
   end
endmodule // srp_pwr

// file: core/srp_top.sv
// Serial control port with reset and power-down control.
`timescale 1ns/1ps
`include "srp_consts.svh"
module srp_top (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic reset_pin_n_i,
   input wire logic sleep_pin_n_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_sclk_i,
   input wire logic spi_sdio_i,
   input wire logic cp_event_i,
   output logic spi_sdio_o,
   output logic spi_sdio_oe_o,
   output logic spi_sdo_o,
   output logic spi_sdo_oe_o,
   output logic pll_pd_o,
   output logic vco_pd_o,
   output logic clkin_pd_o,
   output logic div_pd_o,
   output logic dist_pd_o,
   output logic [11:0] out_pd_mode_o,
   output logic sync_req_o
);
   // Pin synchronisers; the first stage feeds only the second.
   logic rpin_meta_q;
   logic rpin_q;
   logic slp_meta_q;
   logic slp_q;

   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         rpin_meta_q <= 1'b1;
         rpin_q <= 1'b1;
         slp_meta_q <= 1'b1;
         slp_q <= 1'b1;
      end else begin
         rpin_meta_q <= reset_pin_n_i; // see [R27]
         rpin_q <= rpin_meta_q;
         slp_meta_q <= sleep_pin_n_i;
         slp_q <= slp_meta_q;
      end
   end

   wire hard_rst = !rstn_i || !rpin_q; // see [R1] see [R2]
   wire asleep = !slp_q; // see [R5]

   // Serial clock is sampled in the core domain; edges are found against the last sample.
   logic sclk_q;
   always_ff @(posedge core_clk_i) begin
      if (hard_rst) begin
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= spi_sclk_i;
      end
   end

   wire cs_act = !spi_cs_n_i; // see [R15]
   wire rise = cs_act & spi_sclk_i & !sclk_q; // see [R12]
   wire fall = cs_act & !spi_sclk_i & sclk_q; // see [R12]

   // Port state.
   srp_pkg::srp_state_t state_q;
   srp_pkg::srp_state_t state_d;
   logic in_data_q;
   logic [3:0] bit_cnt_q;
   logic [15:0] shreg_q;
   logic rd_q;
   logic [1:0] len_q;
   logic [1:0] left_q;
   logic [12:0] addr_q;
   logic [7:0] tx_q;
   logic [2:0] fcnt_q;
   logic out_bit_q;

   wire [7:0] cfg;
   wire [7:0] rdata;
   wire update;
   wire [1:0] pll_mode;
   wire [11:0] out_mode;
   wire dist_pd_reg;
   wire soft_sync;
   wire soft_rst;

   wire lsb_first = cfg[`SRP_CFG_LSB];
   wire sdo_mode = cfg[`SRP_CFG_SDO];
   wire st_idle = state_q == srp_pkg::ST_IDLE;
   wire st_instr = state_q == srp_pkg::ST_INSTR;
   wire st_data = state_q == srp_pkg::ST_DATA;
   wire st_stall = state_q == srp_pkg::ST_STALL;
   wire st_end = state_q == srp_pkg::ST_END;

   // Either bit order assembles the same word in the shift register.
   wire [15:0] sh_next = lsb_first ? {spi_sdio_i, shreg_q[15:1]} : {shreg_q[14:0], spi_sdio_i};
   wire [7:0] byte_in = lsb_first ? sh_next[15:8] : sh_next[7:0];
   wire instr_done = rise & st_instr & (bit_cnt_q == `SRP_INSTR_LAST); // see [R20]
   wire byte_done = rise & st_data & (bit_cnt_q == `SRP_BYTE_LAST);
   wire is_stream = len_q == `SRP_LEN_STREAM; // see [R23]
   wire at_top = addr_q == {3'h0, `SRP_ADDR_UPD};
   wire last_byte = is_stream ? at_top : (left_q == 2'h0); // see [R19]

   function automatic logic [12:0] step_addr(input logic [12:0] a, input logic inc);
      if (inc) begin
         step_addr = (a >= {3'h0, `SRP_ADDR_UPD}) ? 13'h0000 : a + 13'h0001;
      end else begin
         step_addr = (a == 13'h0000) ? {3'h0, `SRP_ADDR_UPD} : a - 13'h0001;
      end
   endfunction

   wire [12:0] addr_next = step_addr(addr_q, lsb_first); // see [R25]
   wire [12:0] instr_addr = sh_next[12:0]; // see [R22]
   wire [12:0] rd_addr = instr_done ? instr_addr : addr_next;
   wire addr_ok = addr_q[12:10] == 3'h0;
   wire wr_en = byte_done & !rd_q & addr_ok; // see [R12] see [R24]

   // Chip select high mid-byte drops the partial byte and restarts the port.
   wire instr_bound = bit_cnt_q == `SRP_INSTR_HALF;
   wire data_bound = (bit_cnt_q == 4'h0) & !is_stream;

   always_comb begin
      state_d = state_q;
      case (state_q)
         srp_pkg::ST_IDLE: begin
            if (cs_act) begin
               state_d = srp_pkg::ST_INSTR;
            end
         end
         srp_pkg::ST_INSTR: begin
            if (!cs_act) begin
               state_d = instr_bound ? srp_pkg::ST_STALL : srp_pkg::ST_IDLE; // see [R16] see [R18]
            end else if (instr_done) begin
               state_d = srp_pkg::ST_DATA;
            end
         end
         srp_pkg::ST_DATA: begin
            if (!cs_act) begin
               state_d = data_bound ? srp_pkg::ST_STALL : srp_pkg::ST_IDLE; // see [R16] see [R17] see [R18]
            end else if (byte_done && last_byte) begin
               state_d = srp_pkg::ST_END;
            end
         end
         srp_pkg::ST_STALL: begin
            if (cs_act) begin
               state_d = in_data_q ? srp_pkg::ST_DATA : srp_pkg::ST_INSTR; // see [R16]
            end
         end
         srp_pkg::ST_END: begin
            if (!cs_act) begin
               state_d = srp_pkg::ST_IDLE;
            end
         end
         default: begin
            state_d = srp_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (hard_rst) begin
         state_q <= srp_pkg::ST_IDLE;
      end else begin
         state_q <= state_d; // see [R6]
      end
   end

   // Bit counting and instruction capture.
   always_ff @(posedge core_clk_i) begin
      if (hard_rst || st_idle || st_end) begin
         bit_cnt_q <= 4'h0;
         shreg_q <= 16'h0000;
         in_data_q <= 1'b0;
      end else if (instr_done) begin
         bit_cnt_q <= 4'h0;
         shreg_q <= sh_next;
         in_data_q <= 1'b1;
      end else if (byte_done) begin
         bit_cnt_q <= 4'h0;
         shreg_q <= sh_next;
      end else if (rise && (st_instr || st_data)) begin
         bit_cnt_q <= bit_cnt_q + 4'h1;
         shreg_q <= sh_next;
      end
   end

   // Direction, length and address of the data phase.
   always_ff @(posedge core_clk_i) begin
      if (hard_rst) begin
         rd_q <= 1'b0;
         len_q <= 2'h0;
         left_q <= 2'h0;
         addr_q <= 13'h0000;
      end else if (instr_done) begin
         rd_q <= sh_next[15]; // see [R22]
         len_q <= sh_next[14:13];
         left_q <= sh_next[14:13]; // see [R23]
         addr_q <= instr_addr;
      end else if (byte_done) begin
         left_q <= left_q - 2'h1;
         addr_q <= addr_next; // see [R19] see [R25]
      end
   end

   // Read data: loaded on the closing rising edge, launched on falling edges.
   always_ff @(posedge core_clk_i) begin
      if (hard_rst) begin
         tx_q <= 8'h00;
         fcnt_q <= 3'h0;
         out_bit_q <= 1'b0;
      end else if (instr_done || byte_done) begin
         tx_q <= rdata;
         fcnt_q <= 3'h0;
      end else if (fall && st_data && rd_q) begin
         out_bit_q <= lsb_first ? tx_q[fcnt_q] : tx_q[3'h7 - fcnt_q]; // see [R12]
         fcnt_q <= fcnt_q + 3'h1;
      end
   end

   wire drive = cs_act & st_data & rd_q; // see [R14]
   always_ff @(posedge core_clk_i) begin
      if (hard_rst) begin
         spi_sdio_o <= 1'b0;
         spi_sdo_o <= 1'b0;
         spi_sdio_oe_o <= 1'b0;
         spi_sdo_oe_o <= 1'b0;
      end else begin
         spi_sdio_o <= out_bit_q;
         spi_sdo_o <= out_bit_q;
         spi_sdio_oe_o <= drive & !sdo_mode; // see [R13] see [R21]
         spi_sdo_oe_o <= drive & sdo_mode; // see [R13]
      end
   end

   // Writes are produced in the core domain already, so no further crossing is needed.
   srp_regfile u_regs (
      .core_clk_i(core_clk_i),
      .hard_rst_i(hard_rst),
      .we_i(wr_en), // see [R26]
      .waddr_i(addr_q[9:0]),
      .wdata_i(byte_in),
      .raddr_i(rd_addr[9:0]),
      .rdata_o(rdata),
      .update_o(update),
      .cfg_o(cfg),
      .pll_mode_o(pll_mode),
      .out_mode_o(out_mode),
      .dist_pd_o(dist_pd_reg),
      .soft_sync_o(soft_sync),
      .soft_rst_o(soft_rst)
   );

   srp_pwr u_pwr (
      .core_clk_i(core_clk_i),
      .hard_rst_i(hard_rst),
      .asleep_i(asleep),
      .pll_mode_i(pll_mode),
      .dist_pd_i(dist_pd_reg),
      .out_mode_i(out_mode),
      .cp_event_i(cp_event_i),
      .pll_pd_o(pll_pd_o),
      .vco_pd_o(vco_pd_o),
      .clkin_pd_o(clkin_pd_o),
      .div_pd_o(div_pd_o),
      .dist_pd_o(dist_pd_o),
      .out_mode_o(out_pd_mode_o)
   );

   // Output alignment is requested when reset ends or when sleep, soft reset, distribution power-down or soft sync lets go.
   logic rst_q;
   logic asleep_q;
   logic srst_q;
   logic dpd_q;
   logic ssync_q;
   wire align = rst_q | (asleep_q & !asleep) | (srst_q & !soft_rst)
              | (dpd_q & !dist_pd_reg) | (ssync_q & !soft_sync); // see [R1]

   always_ff @(posedge core_clk_i) begin
      if (hard_rst) begin
         rst_q <= 1'b1;
         asleep_q <= 1'b0;
         srst_q <= 1'b0;
         dpd_q <= 1'b0;
         ssync_q <= 1'b0;
         sync_req_o <= 1'b0;
      end else begin
         rst_q <= 1'b0;
         asleep_q <= asleep;
         srst_q <= soft_rst;
         dpd_q <= dist_pd_reg;
         ssync_q <= soft_sync;
         sync_req_o <= align;
      end
   end

   wire unused_ok = update ^ st_stall;
endmodule // srp_top

// file: bench/srp_checker.sv
// Concurrent checks on the pins of the serial port block.
`timescale 1ns/1ps
module srp_checker (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic reset_pin_n_i,
   input wire logic sleep_pin_n_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_sclk_i,
   input wire logic cp_event_i,
   input wire logic spi_sdio_o,
   input wire logic spi_sdio_oe_o,
   input wire logic spi_sdo_oe_o,
   input wire logic pll_pd_o,
   input wire logic vco_pd_o,
   input wire logic clkin_pd_o,
   input wire logic div_pd_o,
   input wire logic [11:0] out_pd_mode_o,
   input wire logic sync_req_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);

   cs_hiz_a: assert property (spi_cs_n_i |=> !spi_sdio_oe_o && !spi_sdo_oe_o)
      else $error("data pin driven while chip select high");
   oe_excl_a: assert property (!(spi_sdio_oe_o && spi_sdo_oe_o))
      else $error("both data pins driven");
   sleep_pd_a: assert property (!sleep_pin_n_i [*4] |-> pll_pd_o && vco_pd_o
      && clkin_pd_o && div_pd_o) else $error("sleep did not power down");
   sleep_safe_a: assert property (!sleep_pin_n_i [*4] |-> out_pd_mode_o == 12'hAAA)
      else $error("outputs not in safe mode during sleep");
   vco_cause_a: assert property ($rose(vco_pd_o) |-> !$past(sleep_pin_n_i, 3))
      else $error("oscillator powered down without sleep");
   pin_reset_a: assert property (!reset_pin_n_i [*3] |=> out_pd_mode_o == 12'h000
      && !sync_req_o && !pll_pd_o) else $error("reset pin ignored");
   por_sync_a: assert property ($rose(rstn_i) |-> ##[1:2] sync_req_o)
      else $error("no alignment request after reset");
   sync_pulse_a: assert property (sync_req_o |=> !sync_req_o)
      else $error("alignment request longer than one cycle");
   sleep_exit_a: assert property ($rose(sleep_pin_n_i) |-> ##[2:5] sync_req_o)
      else $error("no alignment request after sleep");
   rd_launch_a: assert property (spi_sdio_oe_o && $past(spi_sdio_oe_o)
      && $changed(spi_sdio_o) |-> $past(spi_sclk_i, 3) && !$past(spi_sclk_i, 2))
      else $error("read bit changed away from a serial clock fall");

   cover property ($rose(spi_sdio_oe_o));
   cover property ($rose(spi_sdo_oe_o));
   cover property (cp_event_i ##[1:4] $rose(pll_pd_o));
   cover property ($rose(sleep_pin_n_i) ##[1:8] sync_req_o);
endmodule // srp_checker

bind srp_top srp_checker srp_checker_inst (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
   .reset_pin_n_i(reset_pin_n_i), .sleep_pin_n_i(sleep_pin_n_i), .spi_cs_n_i(spi_cs_n_i),
   .spi_sclk_i(spi_sclk_i), .cp_event_i(cp_event_i), .spi_sdio_o(spi_sdio_o),
   .spi_sdio_oe_o(spi_sdio_oe_o), .spi_sdo_oe_o(spi_sdo_oe_o), .pll_pd_o(pll_pd_o),
   .vco_pd_o(vco_pd_o), .clkin_pd_o(clkin_pd_o), .div_pd_o(div_pd_o),
   .out_pd_mode_o(out_pd_mode_o), .sync_req_o(sync_req_o));

// file: bench/srp_host.sv
// Host controller model driving chip select, serial clock and data.
`timescale 1ns/1ps
module srp_host (
   input wire logic core_clk_i,
   input wire logic sdio_i,
   input wire logic sdio_oe_i,
   input wire logic sdo_i,
   input wire logic sdo_oe_i,
   output logic cs_n_o,
   output logic sclk_o,
   output logic line_o
);
   logic drv_en;
   logic drv_val;
   logic tog;
   logic uni;
   logic sdo_line;
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      drv_en = 1'b0;
      drv_val = 1'b0;
      tog = 1'b0;
      uni = 1'b0;
   end
   // An undriven line toggles so that a stale bit never reads as valid.
   always @(posedge core_clk_i) tog <= ~tog;
   assign line_o = sdio_oe_i ? sdio_i : (drv_en ? drv_val : tog);
   assign sdo_line = sdo_oe_i ? sdo_i : tog;

   // Shifts n bits high first; data changes with the clock low and is taken on the rise.
   task automatic bits(input logic [15:0] v, input int n, input logic rd,
                       output logic [15:0] r);
      r = '0;
      if (cs_n_o) begin
         @(negedge core_clk_i) cs_n_o = 1'b0;
         repeat (2) @(negedge core_clk_i);
      end
      for (int i = n - 1; i >= 0; i--) begin
         @(negedge core_clk_i) sclk_o = 1'b0;
         drv_en = !rd;
         drv_val = v[i];
         repeat (3) @(negedge core_clk_i);
         r[i] = uni ? sdo_line : line_o;
         sclk_o = 1'b1;
         repeat (2) @(negedge core_clk_i);
      end
   endtask

   // The clock is parked low only after chip select is high, so no edge is seen.
   task automatic cs_high(input int gap);
      @(negedge core_clk_i) cs_n_o = 1'b1;
      drv_en = 1'b0;
      @(negedge core_clk_i) sclk_o = 1'b0;
      repeat (gap) @(negedge core_clk_i);
   endtask
endmodule // srp_host

// file: bench/tb.sv
// Self-checking bench for the serial port with reset and power-down control.
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
   $display("BAD %0t got %h exp %h", $time, (a), (e)); end end
module tb;
   logic core_clk_i, rstn_i, reset_pin_n_i, sleep_pin_n_i, cp_event_i;
   logic cs_n, sclk, line, sdio_o, sdio_oe, sdo_o, sdo_oe;
   logic pll_pd, vco_pd, clkin_pd, div_pd, dist_pd, sync_req;
   logic [11:0] out_mode;
   logic [15:0] r;
   int fail_count = 0;
   int samples_checked = 0;
   int cyc = 0;

   srp_top srp_top_inst (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
      .reset_pin_n_i(reset_pin_n_i), .sleep_pin_n_i(sleep_pin_n_i), .spi_cs_n_i(cs_n),
      .spi_sclk_i(sclk), .spi_sdio_i(line), .cp_event_i(cp_event_i), .spi_sdio_o(sdio_o),
      .spi_sdio_oe_o(sdio_oe), .spi_sdo_o(sdo_o), .spi_sdo_oe_o(sdo_oe), .pll_pd_o(pll_pd),
      .vco_pd_o(vco_pd), .clkin_pd_o(clkin_pd), .div_pd_o(div_pd), .dist_pd_o(dist_pd),
      .out_pd_mode_o(out_mode), .sync_req_o(sync_req));
   srp_host srp_host_inst (.core_clk_i(core_clk_i), .sdio_i(sdio_o), .sdio_oe_i(sdio_oe),
      .sdo_i(sdo_o), .sdo_oe_i(sdo_oe), .cs_n_o(cs_n), .sclk_o(sclk), .line_o(line));

   initial begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // One instruction and up to three data bytes; a stall raises chip select between bytes.
   task automatic xfer(input logic rd, input logic [1:0] len, input logic [12:0] a,
                       input logic [7:0] d [3], input int n, input logic stall);
      srp_host_inst.bits({rd, len, a}, 16, 1'b0, r);
      for (int i = 0; i < n; i++) begin
         if (stall) begin
            srp_host_inst.cs_high(4);
         end
         srp_host_inst.bits({8'h00, d[i]}, 8, rd, r);
         if (rd) `CHK(r[7:0], d[i])
      end
      srp_host_inst.cs_high(8);
   endtask

   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      xfer(1'b0, 2'b00, a, '{d, 8'h00, 8'h00}, 1, 1'b0);
   endtask

   task automatic rd(input logic [12:0] a, input logic [7:0] e);
      xfer(1'b1, 2'b00, a, '{e, 8'h00, 8'h00}, 1, 1'b0);
   endtask

   // Writes one byte and then applies all buffered changes.
   task automatic setu(input logic [12:0] a, input logic [7:0] d);
      wr(a, d);
      wr(13'h232, 8'h01);
   endtask

   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fail_count++;
         conclude();
      end
   end

   initial begin
      rstn_i = 1'b0;
      reset_pin_n_i = 1'b1;
      sleep_pin_n_i = 1'b1;
      cp_event_i = 1'b0;
      repeat (12) @(negedge core_clk_i);
      rstn_i = 1'b1;
      repeat (3) @(negedge core_clk_i);
      rd(13'h000, 8'h18);
      xfer(1'b0, 2'b10, 13'h0F2, '{8'h02, 8'h03, 8'h02}, 3, 1'b1);
      `CHK(out_mode, 12'h000)
      xfer(1'b1, 2'b10, 13'h0F2, '{8'h02, 8'h03, 8'h02}, 3, 1'b0);
      wr(13'h232, 8'h01);
      `CHK(out_mode, 12'h02E)
      rd(13'h232, 8'h00);
      setu(13'h230, 8'h02);
      `CHK(dist_pd, 1'b1)
      setu(13'h010, 8'h03);
      `CHK(pll_pd, 1'b0)
      @(negedge core_clk_i) cp_event_i = 1'b1;
      @(negedge core_clk_i) cp_event_i = 1'b0;
      repeat (3) @(negedge core_clk_i);
      `CHK(pll_pd, 1'b1)
      setu(13'h010, 8'h00);
      `CHK(pll_pd, 1'b0)
      setu(13'h010, 8'h01);
      `CHK(pll_pd, 1'b1)
      sleep_pin_n_i = 1'b0;
      repeat (5) @(negedge core_clk_i);
      `CHK({pll_pd, vco_pd, clkin_pd, div_pd, out_mode}, 16'hFAAA)
      wr(13'h0F0, 8'h03);
      rd(13'h0F0, 8'h03);
      sleep_pin_n_i = 1'b1;
      repeat (6) @(negedge core_clk_i);
      `CHK({vco_pd, out_mode}, 13'h002E)
      srp_host_inst.bits({3'b000, 13'h0F3}, 16, 1'b0, r);
      srp_host_inst.bits(16'h000F, 4, 1'b0, r);
      srp_host_inst.cs_high(4);
      rd(13'h0F3, 8'h00);
      srp_host_inst.bits(16'h0040, 8, 1'b0, r);
      srp_host_inst.cs_high(4);
      srp_host_inst.bits(16'h0000, 3, 1'b0, r);
      srp_host_inst.cs_high(4);
      rd(13'h000, 8'h18);
      xfer(1'b1, 2'b11, 13'h001, '{8'h00, 8'h18, 8'h00}, 3, 1'b0);
      // Least significant bit first: words go bit-reversed and the bytes are palindromes.
      wr(13'h000, 8'h5A);
      srp_host_inst.bits(16'hCF04, 16, 1'b0, r);
      srp_host_inst.bits(16'h00C3, 8, 1'b0, r);
      srp_host_inst.bits(16'h0081, 8, 1'b0, r);
      srp_host_inst.cs_high(8);
      srp_host_inst.bits(16'hCF01, 16, 1'b0, r);
      srp_host_inst.bits(16'h0000, 8, 1'b1, r);
      `CHK(r[7:0], 8'hC3)
      srp_host_inst.cs_high(8);
      wr(13'h000, 8'h18);
      rd(13'h0F4, 8'h81);
      wr(13'h000, 8'h99);
      srp_host_inst.uni = 1'b1;
      rd(13'h0F1, 8'h03);
      wr(13'h000, 8'h18);
      srp_host_inst.uni = 1'b0;
      wr(13'h000, 8'h3C);
      `CHK({dist_pd, out_mode}, 13'h0000)
      wr(13'h000, 8'h18);
      rd(13'h0F2, 8'h00);
      setu(13'h0F0, 8'h03);
      `CHK(out_mode, 12'h003)
      setu(13'h004, 8'h01);
      wr(13'h0F0, 8'h02);
      rd(13'h0F0, 8'h03);
      `CHK(out_mode, 12'h003)
      reset_pin_n_i = 1'b0;
      repeat (4) @(negedge core_clk_i);
      reset_pin_n_i = 1'b1;
      repeat (5) @(negedge core_clk_i);
      `CHK(out_mode, 12'h000)
      rd(13'h0F0, 8'h00);
      conclude();
   end
endmodule // tb
